// *** core/full_loop_slip.sv ***
// full-loop slip error, encoder rates and positioning complete/close flags
`timescale 1ns/1ps
`default_nettype none
module full_loop_slip
    import slip_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES,
    parameter int RATE_COUNT = RATE_CYCLES,
    parameter int MOTOR_CPR = MOTOR_CPR_DEFAULT
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // encoders and position loop
    input wire enc_step_t enc_step,
    input wire pos_status_t pos_status,
    input wire logic full_loop_active,
    // outputs
    output logic complete_flag,
    output logic close_flag,
    output logic slip_fault,
    output logic irq
);
    initial
    begin
        if (MS_COUNT < 1 || RATE_COUNT < 2 || MOTOR_CPR < 1)
            $error("full_loop_slip: bad timing or resolution parameter");
    end

    // ========================================================================
    // helpers
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction
    function automatic logic signed [1:0] step(input logic p, input logic dir);
        step = p ? (dir ? -2'sd1 : 2'sd1) : 2'sd0;
    endfunction

    // ========================================================================
    // register file
    logic [31:0] slip_limit_q, load_cpr_q;
    logic [15:0] clear_period_q, complete_thr_q, close_thr_q, hold_ms_q;
    logic [2:0] complete_cond_q;
    logic [1:0] close_cond_q;
    logic [3:0] irq_mask_q, irq_status_q, irq_event;
    logic ack_q, wr_go, rd_go, fault_clr;
    logic [31:0] readdata_q;
    logic signed [31:0] slip_q, motor_rate_q, load_rate_q;

    // one wait state: the request completes at the second edge after it appears
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_go = write & ack_q;
    assign rd_go = read & ack_q;
    assign readdata = readdata_q;
    assign fault_clr = wr_go && address == OFS_CTRL && writedata[0];

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            ack_q <= 1'b0;
        else
            ack_q <= (read | write) & ~ack_q;
    end

    // settings are used by the logic on the very next cycle
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            slip_limit_q <= RST_SLIP_LIMIT;
            clear_period_q <= RST_CLEAR_PERIOD;
            complete_cond_q <= RST_COMPLETE_COND;
            complete_thr_q <= RST_COMPLETE_THR;
            close_cond_q <= RST_CLOSE_COND;
            close_thr_q <= RST_CLOSE_THR;
            hold_ms_q <= RST_HOLD_MS;
            load_cpr_q <= RST_LOAD_CPR;
            irq_mask_q <= RST_IRQ_MASK;
        end
        else if (wr_go)
        begin
            unique case (address)
                OFS_SLIP_LIMIT: slip_limit_q <= {1'b0, writedata[30:0]};
                OFS_CLEAR_PERIOD: clear_period_q <= {1'b0, writedata[14:0]};
                OFS_COMPLETE_COND:
                    if (writedata[2:0] <= 3'h4)
                        complete_cond_q <= writedata[2:0];
                OFS_COMPLETE_THR: complete_thr_q <= {1'b0, writedata[14:0]};
                OFS_CLOSE_COND: close_cond_q <= writedata[1:0];
                OFS_CLOSE_THR: close_thr_q <= {1'b0, writedata[14:0]};
                OFS_HOLD_MS: hold_ms_q <= {1'b0, writedata[14:0]};
                OFS_LOAD_CPR:
                    load_cpr_q <= (writedata[30:0] == 31'h0) ? 32'h1 : {1'b0, writedata[30:0]};
                OFS_IRQ_MASK: irq_mask_q <= writedata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            readdata_q <= 32'h0;
        else if (read & ~ack_q)
        begin
            unique case (address)
                OFS_SLIP_LIMIT: readdata_q <= slip_limit_q;
                OFS_SLIP_READBACK: readdata_q <= slip_q;
                OFS_CLEAR_PERIOD: readdata_q <= {16'h0, clear_period_q};
                OFS_MOTOR_RATE: readdata_q <= motor_rate_q;
                OFS_LOAD_RATE: readdata_q <= load_rate_q;
                OFS_COMPLETE_COND: readdata_q <= {29'h0, complete_cond_q};
                OFS_COMPLETE_THR: readdata_q <= {16'h0, complete_thr_q};
                OFS_CLOSE_COND: readdata_q <= {30'h0, close_cond_q};
                OFS_CLOSE_THR: readdata_q <= {16'h0, close_thr_q};
                OFS_HOLD_MS: readdata_q <= {16'h0, hold_ms_q};
                OFS_LOAD_CPR: readdata_q <= load_cpr_q;
                OFS_IRQ_STATUS: readdata_q <= {28'h0, irq_status_q};
                OFS_IRQ_MASK: readdata_q <= {28'h0, irq_mask_q};
                OFS_CTRL: readdata_q <= {31'h0, slip_fault};
                default: readdata_q <= 32'h0;
            endcase
        end
    end

    // ========================================================================
    // interrupts: a new event in the clearing cycle survives
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            irq_status_q <= 4'h0;
        else if (rd_go && address == OFS_IRQ_STATUS)
            irq_status_q <= irq_event;
        else
            irq_status_q <= irq_status_q | irq_event;
    end
    assign irq = |(irq_status_q & irq_mask_q);

    // ========================================================================
    // load count scaled into motor units
    logic signed [1:0] motor_inc, load_inc, load_scaled;
    logic signed [33:0] resid_q, resid_sum;
    logic signed [33:0] cpr_s;
    logic auto_clear;

    assign motor_inc = step(enc_step.motor_pulse, enc_step.motor_dir);
    assign load_inc = step(enc_step.load_pulse, enc_step.load_dir);
    assign cpr_s = $signed({2'b00, load_cpr_q});
    assign resid_sum = resid_q + 34'(load_inc) * 34'(MOTOR_CPR);
    // at most one motor unit leaves per cycle; a finer load encoder is fine,
    // a coarser one lags until the residue drains
    assign load_scaled = (resid_sum >= cpr_s) ? 2'sd1 :
                         (resid_sum <= -cpr_s) ? -2'sd1 : 2'sd0;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || auto_clear)
            resid_q <= 34'sh0;
        else
            resid_q <= resid_sum - 34'(load_scaled) * cpr_s;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || auto_clear)
            slip_q <= 32'sh0;
        else
            slip_q <= slip_q + 32'(motor_inc) - 32'(load_scaled);
    end

    // ========================================================================
    // excess slip fault
    logic slip_over;
    assign slip_over = (slip_limit_q != 32'h0) && (mag(slip_q) > slip_limit_q);
    assign irq_event[IRQ_FAULT] = slip_over & ~slip_fault;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            slip_fault <= 1'b0;
        else if (slip_over)
            slip_fault <= 1'b1;
        else if (fault_clr)
            slip_fault <= 1'b0;
    end

    // ========================================================================
    // periodic clearing on motor revolutions
    logic [31:0] rev_pos_q;
    logic [15:0] rev_cnt_q;
    logic rev_tick;

    assign rev_tick = enc_step.motor_pulse && rev_pos_q == 32'(MOTOR_CPR - 1);
    assign auto_clear = full_loop_active && clear_period_q != 16'h0
        && rev_tick && (rev_cnt_q + 16'h1 >= clear_period_q)
        && (slip_limit_q == 32'h0 || mag(slip_q) < slip_limit_q);
    assign irq_event[IRQ_AUTOCLR] = auto_clear;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            rev_pos_q <= 32'h0;
        else if (enc_step.motor_pulse)
            rev_pos_q <= rev_tick ? 32'h0 : rev_pos_q + 32'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !full_loop_active || clear_period_q == 16'h0)
            rev_cnt_q <= 16'h0;
        else if (rev_tick)
            rev_cnt_q <= (rev_cnt_q + 16'h1 >= clear_period_q) ? 16'h0 : rev_cnt_q + 16'h1;
    end

    // ========================================================================
    // encoder rates over a fixed window
    logic [31:0] win_q;
    logic signed [31:0] motor_acc_q, load_acc_q;
    logic win_end;

    assign win_end = win_q == 32'(RATE_COUNT - 1);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            win_q <= 32'h0;
        else
            win_q <= win_end ? 32'h0 : win_q + 32'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            motor_acc_q <= 32'sh0;
            load_acc_q <= 32'sh0;
            motor_rate_q <= 32'sh0;
            load_rate_q <= 32'sh0;
        end
        else if (win_end)
        begin
            motor_rate_q <= motor_acc_q + 32'(motor_inc);
            load_rate_q <= load_acc_q + 32'(load_inc);
            motor_acc_q <= 32'sh0;
            load_acc_q <= 32'sh0;
        end
        else
        begin
            motor_acc_q <= motor_acc_q + 32'(motor_inc);
            load_acc_q <= load_acc_q + 32'(load_inc);
        end
    end

    // ========================================================================
    // millisecond tick and hold timers
    logic [31:0] ms_q;
    logic ms_tick, in_cmp, in_close;
    logic [15:0] hold_cmp_q, hold_close_q;
    logic held_cmp, held_close, spd_zero, filt_zero;

    assign ms_tick = ms_q == 32'(MS_COUNT - 1);
    assign in_cmp = mag(pos_status.pos_err) < {16'h0, complete_thr_q};
    assign in_close = mag(pos_status.pos_err) < {16'h0, close_thr_q};
    assign held_cmp = in_cmp && hold_cmp_q >= hold_ms_q;
    assign held_close = in_close && hold_close_q >= hold_ms_q;
    assign spd_zero = pos_status.speed_cmd == 32'sh0;
    assign filt_zero = pos_status.filt_speed_cmd == 32'sh0;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            ms_q <= 32'h0;
        else
            ms_q <= ms_tick ? 32'h0 : ms_q + 32'h1;
    end

    // an excursion to or above threshold restarts the hold time
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !in_cmp)
            hold_cmp_q <= 16'h0;
        else if (ms_tick && hold_cmp_q != 16'hFFFF)
            hold_cmp_q <= hold_cmp_q + 16'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !in_close)
            hold_close_q <= 16'h0;
        else if (ms_tick && hold_close_q != 16'hFFFF)
            hold_close_q <= hold_close_q + 16'h1;
    end

    // ========================================================================
    // positioning complete flag
    logic cmp_d;
    always_comb
    begin
        unique case (cond_t'(complete_cond_q))
            CMP_ERR: cmp_d = held_cmp;
            CMP_ERR_SPD: cmp_d = held_cmp & spd_zero;
            CMP_ERR_FILT: cmp_d = held_cmp & filt_zero;
            CMP_ERR_SPD_HOLD: cmp_d = spd_zero & (complete_flag | held_cmp);
            CMP_ERR_SEG: cmp_d = held_cmp & pos_status.multi_seg_done;
            default: cmp_d = 1'b0;
        endcase
    end
    assign irq_event[IRQ_COMPLETE] = cmp_d & ~complete_flag;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            complete_flag <= 1'b0;
        else
            complete_flag <= cmp_d;
    end

    // ========================================================================
    // positioning close flag
    logic close_d;
    always_comb
    begin
        unique case (close_cond_q)
            2'h0: close_d = held_close;
            2'h1: close_d = held_close & spd_zero;
            2'h2: close_d = held_close & filt_zero;
            2'h3: close_d = spd_zero & (close_flag | held_close);
        endcase
    end
    assign irq_event[IRQ_CLOSE] = close_d & ~close_flag;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            close_flag <= 1'b0;
        else
            close_flag <= close_d;
    end

    // ========================================================================
    // checks
    chk_slip_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$past(auto_clear) |-> slip_q == $past(slip_q) + 32'($past(motor_inc))
            - 32'($past(load_scaled)))
        else $error("slip count does not follow encoders");
    chk_fault_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
        slip_over |=> slip_fault)
        else $error("fault not latched on excess slip");
    chk_limit_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        slip_limit_q == 32'h0 |-> !slip_over)
        else $error("protection active with zero limit");
    chk_clear_loop: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_clear |-> full_loop_active ##1 slip_q == 32'sh0)
        else $error("slip cleared outside full loop or not cleared");
    chk_period_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        clear_period_q == 16'h0 |-> !auto_clear)
        else $error("slip cleared with zero period");
    chk_clear_below: assert property (@(posedge ref_clk) disable iff (!nrst)
        auto_clear && slip_limit_q != 32'h0 |-> mag(slip_q) < slip_limit_q)
        else $error("slip cleared above limit");
    chk_close_level: assert property (@(posedge ref_clk) disable iff (!nrst)
        close_cond_q == 2'h0 && !in_close |=> !close_flag)
        else $error("close flag with large error");
    chk_cmp_filt: assert property (@(posedge ref_clk) disable iff (!nrst)
        complete_cond_q == 3'h2 && !filt_zero |=> !complete_flag)
        else $error("complete flag with moving filtered command");
    chk_cmp_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        complete_cond_q == 3'h3 && complete_flag && spd_zero |=> complete_flag)
        else $error("complete flag dropped while speed zero");
    chk_hold_time: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(complete_flag) && complete_cond_q != 3'h3
            |-> $past(hold_cmp_q) >= $past(hold_ms_q))
        else $error("complete flag before hold time");
    chk_rate_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
        win_end |=> motor_rate_q == $past(motor_acc_q) + 32'($past(motor_inc)))
        else $error("motor rate not latched at window end");
    // an event must survive a read-clear that lands in the same cycle
    chk_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_event != 4'h0 |=> (irq_status_q & $past(irq_event)) == $past(irq_event))
        else $error("interrupt status lost an event");

    cov_fault: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(slip_fault));
    cov_autoclr: cover property (@(posedge ref_clk) disable iff (!nrst) auto_clear);
    cov_complete: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(complete_flag));
    cov_close3: cover property (@(posedge ref_clk) disable iff (!nrst)
        close_cond_q == 2'h3 && $fell(close_flag));
endmodule
`default_nettype wire

// *** core/slip_pkg.sv ***
// shared constants, register map and carrier types for the full-loop slip block
package slip_pkg;
    // ========================================================================
    // register byte offsets
    localparam logic [7:0] OFS_SLIP_LIMIT = 8'h00;
    localparam logic [7:0] OFS_SLIP_READBACK = 8'h04;
    localparam logic [7:0] OFS_CLEAR_PERIOD = 8'h08;
    localparam logic [7:0] OFS_MOTOR_RATE = 8'h0C;
    localparam logic [7:0] OFS_LOAD_RATE = 8'h10;
    localparam logic [7:0] OFS_COMPLETE_COND = 8'h14;
    localparam logic [7:0] OFS_COMPLETE_THR = 8'h18;
    localparam logic [7:0] OFS_CLOSE_COND = 8'h1C;
    localparam logic [7:0] OFS_CLOSE_THR = 8'h20;
    localparam logic [7:0] OFS_HOLD_MS = 8'h24;
    localparam logic [7:0] OFS_LOAD_CPR = 8'h28;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
    localparam logic [7:0] OFS_CTRL = 8'h34;
    // ========================================================================
    // values after reset
    localparam logic [31:0] RST_SLIP_LIMIT = 32'h0000_2710;
    localparam logic [15:0] RST_CLEAR_PERIOD = 16'h0014;
    localparam logic [2:0] RST_COMPLETE_COND = 3'h0;
    localparam logic [15:0] RST_COMPLETE_THR = 16'h000A;
    localparam logic [1:0] RST_CLOSE_COND = 2'h0;
    localparam logic [15:0] RST_CLOSE_THR = 16'h0064;
    localparam logic [15:0] RST_HOLD_MS = 16'h000A;
    localparam logic [31:0] RST_LOAD_CPR = 32'h0000_2710;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;
    // ========================================================================
    // interrupt status bit positions
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_COMPLETE = 1;
    localparam int IRQ_CLOSE = 2;
    localparam int IRQ_AUTOCLR = 3;
    localparam int IRQ_BITS = 4;
    // ========================================================================
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_TIME = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
    localparam int RATE_WINDOW_MS = 5;
    localparam int RATE_CYCLES = MS_CYCLES * RATE_WINDOW_MS;
    localparam int MOTOR_CPR_DEFAULT = 10000;
    // ========================================================================
    // carriers
    typedef struct packed {
        logic motor_pulse;
        logic motor_dir;
        logic load_pulse;
        logic load_dir;
    } enc_step_t;
    typedef struct packed {
        logic signed [31:0] pos_err;
        logic signed [31:0] speed_cmd;
        logic signed [31:0] filt_speed_cmd;
        logic multi_seg_done;
    } pos_status_t;
    typedef enum logic [2:0] {
        CMP_ERR, CMP_ERR_SPD, CMP_ERR_FILT, CMP_ERR_SPD_HOLD, CMP_ERR_SEG
    } cond_t;
endpackage

// *** dv/enc_model.sv ***
// motor and load encoder pair model, emitting count pulses on request
`timescale 1ns/1ps
`default_nettype none
module enc_model
    import slip_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // request from the bench
    input wire logic start,
    input wire logic slow,
    input wire logic [15:0] m_cnt,
    input wire logic [15:0] l_cnt,
    input wire logic m_neg,
    input wire logic l_neg,
    // encoder lines
    output enc_step_t enc_step,
    output logic busy
);
    logic [15:0] m_q = 16'h0000;
    logic [15:0] l_q = 16'h0000;
    logic md_q = 1'b0;
    logic ld_q = 1'b0;
    logic slow_q = 1'b0;
    logic ph_q = 1'b0;
    logic en;
    // slow mode leaves an idle cycle between counts
    assign en = !slow_q || ph_q;
    assign busy = (m_q != 16'h0000) || (l_q != 16'h0000);
    // idle direction lines toggle so a stale level never passes for a count
    assign enc_step.motor_pulse = en && (m_q != 16'h0000);
    assign enc_step.motor_dir = enc_step.motor_pulse ? md_q : ph_q;
    assign enc_step.load_pulse = en && (l_q != 16'h0000);
    assign enc_step.load_dir = enc_step.load_pulse ? ld_q : !ph_q;
    always @(posedge ref_clk)
    begin
        ph_q <= !ph_q;
        if (start)
        begin
            m_q <= m_cnt;
            l_q <= l_cnt;
            md_q <= m_neg;
            ld_q <= l_neg;
            slow_q <= slow;
        end
        else
        begin
            if (enc_step.motor_pulse)
                m_q <= m_q - 16'h0001;
            if (enc_step.load_pulse)
                l_q <= l_q - 16'h0001;
        end
    end
endmodule
`default_nettype wire

// *** dv/full_loop_slip_tb_top.sv ***
// self-checking bench for the full-loop slip block
`timescale 1ns/1ps
`default_nettype none
module full_loop_slip_tb_top
    import slip_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, d;
    logic waitrequest, complete_flag, close_flag, slip_fault, irq, busy;
    enc_step_t enc_step;
    pos_status_t pos_status = '{32'sh1F4, 32'sh0, 32'sh0, 1'b0};
    logic full_loop_active = 1'b0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [15:0] m_cnt = 16'h0;
    logic [15:0] l_cnt = 16'h0;
    logic m_neg = 1'b0;
    logic l_neg = 1'b0;
    logic [15:0] lfsr_q = 16'h0022;
    logic signed [31:0] errs [8] = '{0, 9, 10, 50, 99, 100, -9, 500};
    logic signed [31:0] e;
    logic pc, pk;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int tot = 0;
    int exp_slip = 0;
    int m, l;
    // ========================================================================
    // clock, instances, timeout
    always #10 ref_clk = !ref_clk;
    full_loop_slip #(.MS_COUNT(10), .RATE_COUNT(50), .MOTOR_CPR(8)) full_loop_slip_inst (
        .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .enc_step(enc_step), .pos_status(pos_status), .full_loop_active(full_loop_active),
        .complete_flag(complete_flag), .close_flag(close_flag), .slip_fault(slip_fault),
        .irq(irq));
    enc_model enc_model_inst (.ref_clk(ref_clk), .start(start), .slow(slow), .m_cnt(m_cnt),
        .l_cnt(l_cnt), .m_neg(m_neg), .l_neg(l_neg), .enc_step(enc_step), .busy(busy));
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            final_report();
        end
    end
    // ========================================================================
    // helpers
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], 1'b0} ^ (lfsr_q[15] ? 16'h100B : 16'h0000);
        return lfsr_q;
    endfunction
    function automatic logic exp_flag(input int md, input logic sm, input logic sz,
        input logic fz, input logic sg, input logic prev);
        case (md)
            0: return sm;
            1: return sm && sz;
            2: return sm && fz;
            3: return !sz ? 1'b0 : (sm ? 1'b1 : prev);
            default: return sm && sg;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bit_chk(input logic b, input logic x);
        chk({31'h0, b}, {31'h0, x});
    endtask
    // every bus cycle starts just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        address <= a;
        writedata <= v;
        read <= !wr;
        write <= wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(d, x);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic pulses(input int mc, input int lc, input logic mn, input logic ln,
        input logic wt);
        start <= 1'b1;
        slow <= wt && (rnd() > 16'h7FFF);
        m_cnt <= 16'(mc);
        l_cnt <= 16'(lc);
        m_neg <= mn;
        l_neg <= ln;
        @(posedge ref_clk);
        start <= 1'b0;
        tot = tot + mc;
        exp_slip = exp_slip + (mn ? -mc : mc) - (ln ? -lc : lc) / 2;
        if (wt)
            do @(posedge ref_clk); while (busy !== 1'b0);
    endtask
    task automatic final_report();
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ========================================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_SLIP_LIMIT, 32'h0000_2710);
        rd(OFS_CLEAR_PERIOD, 32'h0000_0014);
        rd(OFS_COMPLETE_COND, 32'h0);
        rd(OFS_COMPLETE_THR, 32'h0000_000A);
        rd(OFS_CLOSE_COND, 32'h0);
        rd(8'h3C, 32'h0);
        // two load counts make one motor count
        wr(OFS_LOAD_CPR, 32'h0000_0010);
        wr(OFS_SLIP_LIMIT, 32'h0000_03E8);
        wr(OFS_CLEAR_PERIOD, 32'h0);
        full_loop_active <= 1'b1;
        repeat (6)
        begin
            m = rnd() % 16;
            l = (rnd() % 8) * 2;
            pulses(m, l, rnd() > 16'h7FFF, rnd() > 16'h7FFF, 1'b1);
            rd(OFS_SLIP_READBACK, exp_slip);
        end
        pulses(150, 0, 1'b0, 1'b0, 1'b1);
        rd(OFS_SLIP_READBACK, exp_slip);
        full_loop_active <= 1'b0;
        wr(OFS_CLEAR_PERIOD, 32'h1);
        pulses(8, 0, 1'b0, 1'b0, 1'b1);
        rd(OFS_SLIP_READBACK, exp_slip);
        full_loop_active <= 1'b1;
        pulses(8 - tot % 8, 0, 1'b0, 1'b0, 1'b1);
        exp_slip = 0;
        rd(OFS_SLIP_READBACK, exp_slip);
        rd(OFS_IRQ_STATUS, 32'h0000_0008);
        wr(OFS_CLEAR_PERIOD, 32'h0);
        wr(OFS_SLIP_LIMIT, 32'h4);
        pulses(6, 0, 1'b0, 1'b0, 1'b1);
        bit_chk(slip_fault, 1'b1);
        bit_chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h1);
        bit_chk(irq, 1'b1);
        rd(OFS_IRQ_STATUS, 32'h0000_0001);
        bit_chk(irq, 1'b0);
        wr(OFS_SLIP_LIMIT, 32'h0);
        wr(OFS_CTRL, 32'h1);
        pulses(20, 0, 1'b0, 1'b0, 1'b1);
        bit_chk(slip_fault, 1'b0);
        pulses(200, 200, 1'b0, 1'b1, 1'b0);
        repeat (130) @(posedge ref_clk);
        rd(OFS_MOTOR_RATE, 32'h0000_0032);
        rd(OFS_LOAD_RATE, 32'hFFFF_FFCE);
        while (busy !== 1'b0) @(posedge ref_clk);
        wr(OFS_HOLD_MS, 32'h2);
        pos_status.pos_err <= 32'sh0;
        repeat (8) @(posedge ref_clk);
        bit_chk(complete_flag, 1'b0);
        repeat (40) @(posedge ref_clk);
        bit_chk(complete_flag, 1'b1);
        for (int i = 0; i < 40; i++)
        begin
            // a latching mode starts from an unknown state
            if (i % 8 == 0)
                pc = 1'bx;
            if (i % 10 == 0)
                pk = 1'bx;
            wr(OFS_COMPLETE_COND, 32'(i / 8));
            wr(OFS_CLOSE_COND, 32'(i / 10));
            pos_status.pos_err <= errs[rnd() % 8];
            pos_status.speed_cmd <= (rnd() > 16'h7FFF) ? 32'sh0 : 32'(rnd());
            pos_status.filt_speed_cmd <= (rnd() > 16'h7FFF) ? 32'sh0 : 32'(rnd());
            pos_status.multi_seg_done <= rnd() > 16'h7FFF;
            repeat (45) @(posedge ref_clk);
            e = pos_status.pos_err;
            pc = exp_flag(i / 8, e < 10 && e > -10, pos_status.speed_cmd == 0,
                pos_status.filt_speed_cmd == 0, pos_status.multi_seg_done, pc);
            pk = exp_flag(i / 10, e < 100 && e > -100, pos_status.speed_cmd == 0,
                pos_status.filt_speed_cmd == 0, 1'b0, pk);
            if (pc !== 1'bx)
                bit_chk(complete_flag, pc);
            if (pk !== 1'bx)
                bit_chk(close_flag, pk);
        end
        final_report();
    end
endmodule
`default_nettype wire
